// ===== logic/fwos_regs.svh
// register offsets, field positions, reset values and timing counts of the flash write sequencer
`ifndef FWOS_REGS_SVH
`define FWOS_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FWOS_OFF_CTL_LO     8'h00
`define FWOS_OFF_CTL_HI     8'h04
`define FWOS_OFF_SEC_LO     8'h08
`define FWOS_OFF_SEC_HI     8'h0c
`define FWOS_OFF_ADR_LO     8'h10
`define FWOS_OFF_ADR_HI     8'h14
`define FWOS_OFF_D0_LO      8'h18
`define FWOS_OFF_D0_HI      8'h1c
`define FWOS_OFF_D1_LO      8'h20
`define FWOS_OFF_D1_HI      8'h24
`define FWOS_OFF_ERR        8'h28
`define FWOS_OFF_TAU        8'h2c
`define FWOS_OFF_STAT       8'h30
`define FWOS_OFF_MASK       8'h34
`define FWOS_OFF_PROT       8'h38

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FWOS_CTL_LAUNCH     15
`define FWOS_CTL_SUSPEND_SELECT       14
`define FWOS_CTL_WP         13
`define FWOS_CTL_DWP        12
`define FWOS_CTL_ER         11
`define FWOS_CTL_SPR        8
`define FWOS_CTL_MASK       16'hf900
`define FWOS_SEL_MASK       16'h3900
`define FWOS_ERR_RESUME     0
`define FWOS_ERR_REFUSED    1
`define FWOS_EV_DONE        0
`define FWOS_EV_RESUME      1
`define FWOS_EV_REFUSED     2
`define FWOS_PAT_DISABLE    0
`define FWOS_PAT_ENABLE     1
`define FWOS_WORD_SEL_BIT   2

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define FWOS_PROT_RST       1'b0
`define FWOS_TOGGLE_MAX     5'h10

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FWOS_CLK_NS         5
`define FWOS_PROG_NS        1000
`define FWOS_ERASE_NS       5000
`define FWOS_SPR_NS         1000
`define FWOS_PROG_CYC       16'((`FWOS_PROG_NS) / (`FWOS_CLK_NS))
`define FWOS_ERASE_CYC      16'((`FWOS_ERASE_NS) / (`FWOS_CLK_NS))
`define FWOS_SPR_CYC        16'((`FWOS_SPR_NS) / (`FWOS_CLK_NS))

`endif

// ===== logic/fwos_pkg.sv
// types of the flash write sequencer
package fwos_pkg;

    typedef enum logic [2:0] {
        FWOS_ST_IDLE = 3'b001,
        FWOS_ST_BUSY = 3'b010,
        FWOS_ST_SUSPEND_SELECT = 3'b100
    } fwos_state_t;

    typedef enum logic [2:0] {
        FWOS_OP_NONE = 3'h0,
        FWOS_OP_WP   = 3'h1,
        FWOS_OP_DWP  = 3'h2,
        FWOS_OP_ER   = 3'h3,
        FWOS_OP_SPR  = 3'h4
    } fwos_op_t;

endpackage

// ===== logic/fwos_op_timer.sv
// operation duration counter that pauses while not running
`timescale 1ns/1ps
module fwos_op_timer (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // control
    input  wire logic        load_i,
    input  wire logic [15:0] cycles_i,
    input  wire logic        run_i,
    // result
    output logic             done_o
);
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic        done_r;
    logic        done_nxt;

    always_comb begin
        // a finish that coincides with a pause is kept until the count runs again
        cnt_nxt  = cnt_r;
        done_nxt = done_r && !run_i;
        if (load_i) begin
            cnt_nxt = cycles_i;
        end else if (run_i && cnt_r != 16'h0000) begin
            cnt_nxt  = cnt_r - 16'h0001;
            done_nxt = (cnt_r == 16'h0001);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r  <= 16'h0000;
            done_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign done_o = done_r;
endmodule // fwos_op_timer

// ===== logic/fwos_seq.sv
// flash write operation sequencer with a classic wishbone register slave
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "fwos_regs.svh"
module fwos_seq (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // code fetch source, needed to set the temp unprotect bit
    input  wire logic        exec_from_flash_i,
    // flash array command
    output logic             arr_start_o,
    output logic [2:0]       arr_op_o,
    output logic [23:0]      arr_addr_o,
    output logic [63:0]      arr_data_o,
    output logic [31:0]      arr_sect_o,
    output logic             arr_suspend_o,
    // interrupt
    output logic             irq_o
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    fwos_pkg::fwos_state_t state_r, state_nxt;
    fwos_pkg::fwos_op_t    op_r, op_nxt;
    logic [15:0] ctl_r, ctl_nxt, sec_lo_r, sec_lo_nxt, sec_hi_r, sec_hi_nxt;
    logic [15:0] adl_r, adl_nxt, adh_r, adh_nxt;
    logic [15:0] d0l_r, d0l_nxt, d0h_r, d0h_nxt, d1l_r, d1l_nxt, d1h_r, d1h_nxt;
    logic [15:0] saved_r, saved_nxt;
    logic [1:0]  err_r, err_nxt;
    logic [2:0]  stat_r, stat_nxt, mask_r, mask_nxt, stat_set;
    logic        tau_r, tau_nxt, prot_r, prot_nxt;
    logic [4:0]  tog_r, tog_nxt;
    logic        ack_r, ack_nxt, irq_r, irq_nxt;
    logic [31:0] rdat_r, rdat_nxt;
    logic        start_r, start_nxt, suspend_select_r, suspend_select_nxt;
    logic [2:0]  aop_r, aop_nxt;
    logic [23:0] aadr_r, aadr_nxt;
    logic [63:0] adat_r, adat_nxt;
    logic [31:0] asec_r, asec_nxt;
    logic        tmr_load;
    logic [15:0] tmr_cyc;
    logic        tmr_done;
    logic [15:0] rd_val;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire logic [7:0]  off     = {wb_adr_i[7:2], 2'b00};
    wire logic        acc     = wb_cyc_i && wb_stb_i && ack_r;
    wire logic        wr_acc  = acc && wb_we_i;
    wire logic        rd_acc  = acc && !wb_we_i;
    wire logic        blocked = prot_r && !tau_r;
    wire logic        wr_ctl  = wr_acc && off == `FWOS_OFF_CTL_HI && !blocked;
    wire logic [15:0] ctl_in  = wmerge(ctl_r, wb_dat_i, wb_sel_i) & `FWOS_CTL_MASK;
    wire fwos_pkg::fwos_op_t op_in = op_of(ctl_in);

    function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        wmerge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // exactly one selection bit gives an operation
    function automatic fwos_pkg::fwos_op_t op_of(input logic [15:0] c);
        case ({c[`FWOS_CTL_WP], c[`FWOS_CTL_DWP], c[`FWOS_CTL_ER], c[`FWOS_CTL_SPR]})
            4'b1000: op_of = fwos_pkg::FWOS_OP_WP;
            4'b0100: op_of = fwos_pkg::FWOS_OP_DWP;
            4'b0010: op_of = fwos_pkg::FWOS_OP_ER;
            4'b0001: op_of = fwos_pkg::FWOS_OP_SPR;
            default: op_of = fwos_pkg::FWOS_OP_NONE;
        endcase
    endfunction

    function automatic logic [15:0] op_cycles(input fwos_pkg::fwos_op_t o);
        case (o)
            fwos_pkg::FWOS_OP_ER:  op_cycles = `FWOS_ERASE_CYC;
            fwos_pkg::FWOS_OP_SPR: op_cycles = `FWOS_SPR_CYC;
            default:               op_cycles = `FWOS_PROG_CYC;
        endcase
    endfunction

    fwos_op_timer u_timer (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .load_i   (tmr_load),
        .cycles_i (tmr_cyc),
        .run_i    (state_r == fwos_pkg::FWOS_ST_BUSY),
        .done_o   (tmr_done)
    );

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_comb begin
        case (off)
            `FWOS_OFF_CTL_LO: rd_val = {13'h0000, state_r};
            `FWOS_OFF_CTL_HI: rd_val = ctl_r;
            `FWOS_OFF_SEC_LO: rd_val = sec_lo_r;
            `FWOS_OFF_SEC_HI: rd_val = sec_hi_r;
            `FWOS_OFF_ADR_LO: rd_val = adl_r;
            `FWOS_OFF_ADR_HI: rd_val = adh_r;
            `FWOS_OFF_D0_LO:  rd_val = d0l_r;
            `FWOS_OFF_D0_HI:  rd_val = d0h_r;
            `FWOS_OFF_D1_LO:  rd_val = d1l_r;
            `FWOS_OFF_D1_HI:  rd_val = d1h_r;
            `FWOS_OFF_ERR:    rd_val = {14'h0000, err_r};
            `FWOS_OFF_TAU:    rd_val = {15'h0000, tau_r};
            `FWOS_OFF_STAT:   rd_val = {13'h0000, stat_r};
            `FWOS_OFF_MASK:   rd_val = {13'h0000, mask_r};
            `FWOS_OFF_PROT:   rd_val = {10'h000, tog_r, prot_r};
            default:          rd_val = 16'h0000;
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r; op_nxt = op_r; ctl_nxt = ctl_r; saved_nxt = saved_r;
        sec_lo_nxt = sec_lo_r; sec_hi_nxt = sec_hi_r; adl_nxt = adl_r; adh_nxt = adh_r;
        d0l_nxt = d0l_r; d0h_nxt = d0h_r; d1l_nxt = d1l_r; d1h_nxt = d1h_r;
        err_nxt = err_r; mask_nxt = mask_r; tau_nxt = tau_r; prot_nxt = prot_r; tog_nxt = tog_r;
        aop_nxt = aop_r; aadr_nxt = aadr_r; adat_nxt = adat_r; asec_nxt = asec_r;
        suspend_select_nxt = suspend_select_r; start_nxt = 1'b0; stat_set = 3'b000;
        tmr_load = 1'b0; tmr_cyc = 16'h0000;
        ack_nxt  = wb_cyc_i && wb_stb_i && !ack_r;
        rdat_nxt = (wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i) ? {16'h0000, rd_val} : rdat_r;

        // plain register writes; protected ones are dropped while locked
        if (wr_acc) begin
            case (off)
                `FWOS_OFF_CTL_HI: if (!blocked && state_r != fwos_pkg::FWOS_ST_BUSY) ctl_nxt = ctl_in;
                `FWOS_OFF_SEC_LO: if (!blocked) sec_lo_nxt = wmerge(sec_lo_r, wb_dat_i, wb_sel_i);
                `FWOS_OFF_SEC_HI: if (!blocked) sec_hi_nxt = wmerge(sec_hi_r, wb_dat_i, wb_sel_i);
                `FWOS_OFF_ADR_LO: if (!blocked) adl_nxt = wmerge(adl_r, wb_dat_i, wb_sel_i);
                `FWOS_OFF_ADR_HI: if (!blocked) adh_nxt = wmerge(adh_r, wb_dat_i, wb_sel_i);
                `FWOS_OFF_D0_LO:  if (!blocked) d0l_nxt = wmerge(d0l_r, wb_dat_i, wb_sel_i);
                `FWOS_OFF_D0_HI:  if (!blocked) d0h_nxt = wmerge(d0h_r, wb_dat_i, wb_sel_i);
                `FWOS_OFF_D1_LO:  if (!blocked) d1l_nxt = wmerge(d1l_r, wb_dat_i, wb_sel_i);
                `FWOS_OFF_D1_HI:  if (!blocked) d1h_nxt = wmerge(d1h_r, wb_dat_i, wb_sel_i);
                `FWOS_OFF_ERR:    if (wb_sel_i[0]) err_nxt = wb_dat_i[1:0];
                `FWOS_OFF_MASK:   if (wb_sel_i[0]) mask_nxt = wb_dat_i[2:0];
                // setting needs a fetch from flash, clearing is always allowed
                `FWOS_OFF_TAU:    if (wb_sel_i[0] && (!wb_dat_i[0] || exec_from_flash_i)) tau_nxt = wb_dat_i[0];
                default: ;
            endcase
        end

        case (state_r)
            fwos_pkg::FWOS_ST_IDLE: begin
                if (wr_ctl && ctl_in[`FWOS_CTL_LAUNCH]) begin
                    ctl_nxt[`FWOS_CTL_LAUNCH] = 1'b0;
                    if (ctl_r[`FWOS_CTL_SUSPEND_SELECT] || ctl_in[`FWOS_CTL_SUSPEND_SELECT]) begin
                        err_nxt[`FWOS_ERR_REFUSED] = 1'b1;
                        stat_set[`FWOS_EV_REFUSED] = 1'b1;
                    end else if (op_in == fwos_pkg::FWOS_OP_NONE) begin
                        err_nxt[`FWOS_ERR_REFUSED] = 1'b1;
                        stat_set[`FWOS_EV_REFUSED] = 1'b1;
                    end else begin
                        ctl_nxt[`FWOS_CTL_LAUNCH] = 1'b1;
                        state_nxt = fwos_pkg::FWOS_ST_BUSY;
                        op_nxt    = op_in;
                        saved_nxt = ctl_in & `FWOS_SEL_MASK;
                        start_nxt = 1'b1;
                        aop_nxt   = op_in;
                        aadr_nxt  = {adh_r[7:0], adl_r};
                        if (op_in == fwos_pkg::FWOS_OP_DWP) aadr_nxt[`FWOS_WORD_SEL_BIT] = 1'b0;
                        adat_nxt  = (op_in == fwos_pkg::FWOS_OP_DWP) ? {d1h_r, d1l_r, d0h_r, d0l_r}
                                                                     : {32'h0, d0h_r, d0l_r};
                        asec_nxt  = {sec_hi_r, sec_lo_r};
                        tmr_load  = 1'b1;
                        tmr_cyc   = op_cycles(op_in);
                    end
                end
            end
            fwos_pkg::FWOS_ST_BUSY: begin
                if (tmr_done) begin
                    state_nxt = fwos_pkg::FWOS_ST_IDLE;
                    ctl_nxt   = 16'h0000;
                    stat_set[`FWOS_EV_DONE] = 1'b1;
                    if (op_r == fwos_pkg::FWOS_OP_ER) begin
                        sec_lo_nxt = 16'h0000;
                        sec_hi_nxt = 16'h0000;
                    end
                    if (op_r == fwos_pkg::FWOS_OP_SPR && tog_r != `FWOS_TOGGLE_MAX) begin
                        if (prot_r && !d0l_r[`FWOS_PAT_DISABLE]) begin
                            prot_nxt = 1'b0;
                            tog_nxt  = tog_r + 5'h01;
                        end else if (!prot_r && !d0l_r[`FWOS_PAT_ENABLE]) begin
                            prot_nxt = 1'b1;
                            tog_nxt  = tog_r + 5'h01;
                        end
                    end
                end else if (wr_ctl && ctl_in[`FWOS_CTL_SUSPEND_SELECT] && op_r != fwos_pkg::FWOS_OP_SPR) begin
                    state_nxt = fwos_pkg::FWOS_ST_SUSPEND_SELECT;
                    ctl_nxt   = ctl_r | (16'h0001 << `FWOS_CTL_SUSPEND_SELECT);
                    suspend_select_nxt  = 1'b1;
                end
            end
            fwos_pkg::FWOS_ST_SUSPEND_SELECT: begin
                if (wr_ctl && ctl_in[`FWOS_CTL_LAUNCH]) begin
                    if (!ctl_in[`FWOS_CTL_SUSPEND_SELECT] && (ctl_in & `FWOS_SEL_MASK) == saved_r) begin
                        state_nxt = fwos_pkg::FWOS_ST_BUSY;
                        suspend_select_nxt  = 1'b0;
                    end else begin
                        state_nxt = fwos_pkg::FWOS_ST_IDLE;
                        ctl_nxt   = 16'h0000;
                        suspend_select_nxt  = 1'b0;
                        err_nxt[`FWOS_ERR_RESUME] = 1'b1;
                        stat_set[`FWOS_EV_RESUME] = 1'b1;
                        tmr_load  = 1'b1;
                    end
                end
            end
            default: state_nxt = fwos_pkg::FWOS_ST_IDLE;
        endcase

        // a new event wins over the clearing read
        stat_nxt = ((rd_acc && off == `FWOS_OFF_STAT) ? 3'b000 : stat_r) | stat_set;
        irq_nxt  = |(stat_nxt & mask_nxt);
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= fwos_pkg::FWOS_ST_IDLE; op_r <= fwos_pkg::FWOS_OP_NONE;
            ctl_r <= 16'h0000; saved_r <= 16'h0000; sec_lo_r <= 16'h0000; sec_hi_r <= 16'h0000;
            adl_r <= 16'h0000; adh_r <= 16'h0000; d0l_r <= 16'h0000; d0h_r <= 16'h0000;
            d1l_r <= 16'h0000; d1h_r <= 16'h0000; err_r <= 2'h0; stat_r <= 3'h0; mask_r <= 3'h0;
            tau_r <= 1'b0; prot_r <= `FWOS_PROT_RST; tog_r <= 5'h00;
            ack_r <= 1'b0; irq_r <= 1'b0; rdat_r <= 32'h0000_0000;
            start_r <= 1'b0; suspend_select_r <= 1'b0; aop_r <= 3'h0; aadr_r <= 24'h00_0000;
            adat_r <= 64'h0; asec_r <= 32'h0000_0000;
        end else begin
            state_r <= state_nxt; op_r <= op_nxt;
            ctl_r <= ctl_nxt; saved_r <= saved_nxt; sec_lo_r <= sec_lo_nxt; sec_hi_r <= sec_hi_nxt;
            adl_r <= adl_nxt; adh_r <= adh_nxt; d0l_r <= d0l_nxt; d0h_r <= d0h_nxt;
            d1l_r <= d1l_nxt; d1h_r <= d1h_nxt; err_r <= err_nxt; stat_r <= stat_nxt; mask_r <= mask_nxt;
            tau_r <= tau_nxt; prot_r <= prot_nxt; tog_r <= tog_nxt;
            ack_r <= ack_nxt; irq_r <= irq_nxt; rdat_r <= rdat_nxt;
            start_r <= start_nxt; suspend_select_r <= suspend_select_nxt; aop_r <= aop_nxt; aadr_r <= aadr_nxt;
            adat_r <= adat_nxt; asec_r <= asec_nxt;
        end
    end

    assign wb_dat_o      = rdat_r;
    assign wb_ack_o      = ack_r;
    assign irq_o         = irq_r;
    assign arr_start_o   = start_r;
    assign arr_op_o      = aop_r;
    assign arr_addr_o    = aadr_r;
    assign arr_data_o    = adat_r;
    assign arr_sect_o    = asec_r;
    assign arr_suspend_o = suspend_select_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_LAUNCH_ONLY: assert property (start_r |-> $past(wr_ctl && ctl_in[`FWOS_CTL_LAUNCH]))
        else $error("array start without a launch write");
    AST_CANCEL: assert property (state_r == fwos_pkg::FWOS_ST_IDLE && !(wr_ctl && ctl_in[`FWOS_CTL_LAUNCH])
        |=> state_r == fwos_pkg::FWOS_ST_IDLE && !start_r)
        else $error("operation began without launch");
    AST_WORD_DATA: assert property (start_r && aop_r == fwos_pkg::FWOS_OP_WP
        |-> adat_r == {32'h0, d0h_r, d0l_r} && aadr_r == {adh_r[7:0], adl_r})
        else $error("word program operands wrong");
    AST_ERASE_SECT: assert property (start_r && aop_r == fwos_pkg::FWOS_OP_ER |-> asec_r == {sec_hi_r, sec_lo_r})
        else $error("erase sectors wrong");
    AST_SUSPEND: assert property (state_r == fwos_pkg::FWOS_ST_BUSY && !tmr_done && wr_ctl && ctl_in[`FWOS_CTL_SUSPEND_SELECT]
        && op_r != fwos_pkg::FWOS_OP_SPR |=> suspend_select_r ##1 suspend_select_r || state_r != fwos_pkg::FWOS_ST_BUSY)
        else $error("suspend not applied");
    AST_TOGGLE_CAP: assert property (tog_r == `FWOS_TOGGLE_MAX |=> $stable(prot_r) && tog_r == `FWOS_TOGGLE_MAX)
        else $error("protection toggled past limit");
    AST_SUSPEND_SELECT_LAUNCH: assert property (state_r == fwos_pkg::FWOS_ST_IDLE && wr_ctl && ctl_in[`FWOS_CTL_LAUNCH]
        && ctl_r[`FWOS_CTL_SUSPEND_SELECT] |=> !start_r && err_r[`FWOS_ERR_REFUSED])
        else $error("launch with suspend set was accepted");
    AST_RESUME_ERR: assert property (state_r == fwos_pkg::FWOS_ST_SUSPEND_SELECT && wr_ctl && ctl_in[`FWOS_CTL_LAUNCH]
        && (ctl_in & `FWOS_SEL_MASK) != saved_r
        |=> err_r[`FWOS_ERR_RESUME] && state_r == fwos_pkg::FWOS_ST_IDLE)
        else $error("bad resume not aborted");
    AST_DW_ALIGN: assert property (start_r && aop_r == fwos_pkg::FWOS_OP_DWP |-> !aadr_r[`FWOS_WORD_SEL_BIT])
        else $error("double word address not aligned");
    AST_PROT_BLOCK: assert property (wr_acc && blocked && off == `FWOS_OFF_CTL_HI
        && state_r == fwos_pkg::FWOS_ST_IDLE |=> $stable(ctl_r))
        else $error("control write accepted while protected");
endmodule // fwos_seq

// ===== tb/fwos_seq_tb.sv
// self-checking bench of the flash write sequencer
`timescale 1ns/1ps
module fwos_seq_tb;
    // ----------------------------------------------------------------
    // ports and model state
    // ----------------------------------------------------------------
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic        exec_from_flash_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, q, arr_sect_o;
    logic        wb_ack_o, arr_start_o, arr_suspend_o, irq_o;
    logic [2:0]  arr_op_o;
    logic [23:0] arr_addr_o;
    logic [63:0] arr_data_o;
    logic [15:0] r [8];
    logic [15:0] sel, nv;
    int          err_count = 0, n_checks = 0, prot = 0, cnt = 0, shadow = 0;

    always #2.5 clk_i = ~clk_i;

    fwos_seq u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
                    .wb_dat_o, .wb_ack_o, .exec_from_flash_i, .arr_start_o, .arr_op_o, .arr_addr_o,
                    .arr_data_o, .arr_sect_o, .arr_suspend_o, .irq_o);

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'h3;
        wb_dat_i <= {16'h0, d};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) begin
            @(posedge clk_i);
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wait_idle;
        for (int i = 0; i < 1000; i++) begin
            wb(1'b0, 8'h00, 16'h0);
            if (q === 32'h1) break;
        end
        chk(q, 32'h1);
    endtask

    task automatic complete_run;
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        complete_run();
    end

    initial begin
        void'($urandom(78));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 8'h00, 16'h0);
        chk(q, 32'h1);
        wb(1'b0, 8'h38, 16'h0);
        chk(q, 32'h0);
        wb(1'b1, 8'h34, 16'h0007);
        // word, double word and erase with random operands
        for (int op = 1; op <= 3; op++) begin
            sel = (op == 1) ? 16'h2000 : (op == 2) ? 16'h1000 : 16'h0800;
            wb(1'b1, 8'h04, sel);
            chk(arr_start_o, 1'b0);
            for (int k = 0; k < 8; k++) begin
                r[k] = 16'($urandom);
                wb(1'b1, 8'(8 + 4 * k), r[k]);
            end
            wb(1'b1, 8'h04, sel | 16'h8000);
            chk(arr_start_o, 1'b1);
            chk(arr_op_o, 3'(op));
            if (op == 3) chk(arr_sect_o, {r[1], r[0]});
            else begin
                chk(arr_addr_o, {r[3][7:0], r[2] & ((op == 2) ? 16'hfffb : 16'hffff)});
                chk(arr_data_o, {((op == 2) ? {r[7], r[6]} : 32'h0), r[5], r[4]});
            end
            wait_idle();
            chk(irq_o, 1'b1);
            wb(1'b0, 8'h30, 16'h0);
            chk(q, 32'h1);
            @(posedge clk_i);
            chk(irq_o, 1'b0);
        end
        wb(1'b0, 8'h08, 16'h0);
        chk(q, 32'h0);
        // suspend an erase, then resume with a different selection
        wb(1'b1, 8'h04, 16'h0800);
        wb(1'b1, 8'h08, 16'h0001);
        wb(1'b1, 8'h04, 16'h8800);
        wb(1'b1, 8'h04, 16'h4000);
        wb(1'b0, 8'h00, 16'h0);
        chk(q, 32'h4);
        chk(arr_suspend_o, 1'b1);
        wb(1'b1, 8'h04, 16'ha000);
        wb(1'b0, 8'h28, 16'h0);
        chk(q, 32'h1);
        chk(arr_suspend_o, 1'b0);
        wb(1'b0, 8'h30, 16'h0);
        chk(q, 32'h2);
        // launch with suspend set, and launch after a cancelled selection
        for (int c = 0; c < 2; c++) begin
            wb(1'b1, 8'h28, 16'h0);
            wb(1'b1, 8'h04, c ? 16'h2000 : 16'h4800);
            wb(1'b1, 8'h04, c ? 16'h0000 : 16'h4800);
            wb(1'b1, 8'h04, c ? 16'h8000 : 16'hc800);
            chk(arr_start_o, 1'b0);
            wb(1'b0, 8'h28, 16'h0);
            chk(q, 32'h2);
            wb(1'b0, 8'h30, 16'h0);
            chk(q, 32'h4);
            wb(1'b1, 8'h04, 16'h0000);
        end
        // protection toggles until the lifetime limit
        shadow = r[2];
        for (int i = 0; i < 17; i++) begin
            exec_from_flash_i <= 1'b1;
            wb(1'b1, 8'h2c, 16'h0001);
            exec_from_flash_i <= 1'b0;
            wb(1'b1, 8'h04, 16'h0100);
            wb(1'b1, 8'h18, prot ? 16'hfffe : 16'hfffd);
            wb(1'b1, 8'h04, 16'h8100);
            chk(arr_op_o, 3'h4);
            wait_idle();
            if (cnt < 16) begin
                prot = 1 - prot;
                cnt++;
            end
            wb(1'b1, 8'h2c, 16'h0000);
            wb(1'b0, 8'h38, 16'h0);
            chk(q, 32'(cnt * 2 + prot));
            nv = 16'($urandom);
            wb(1'b1, 8'h10, nv);
            if (prot == 0) shadow = nv;
            wb(1'b0, 8'h10, 16'h0);
            chk(q, 32'(shadow));
        end
        complete_run();
    end
endmodule // fwos_seq_tb
